/* File: rtl/dist_pkg.sv */
// ------------------------------------------------------------------
// shared constants of the active-clear and priority register slice
// ------------------------------------------------------------------
package dist_pkg;

  // build shape: two processors, one extra word of shared lines
  localparam int          NCPU              = 2;
  localparam int          CPU_W             = 1;
  localparam int          LINE_COUNT        = 1;   // interrupt_line_count_field
  localparam int          INTR_PER_WORD     = 32;
  localparam int          FIELDS_PER_WORD   = 4;
  localparam int          FIELD_W           = 8;
  localparam int          BANKED_INTR       = 32;  // ids 0-31 per processor
  localparam int          NINTR             = INTR_PER_WORD * (LINE_COUNT + 1);
  localparam int          NSPI              = NINTR - BANKED_INTR;
  localparam int          ID_W              = 6;
  localparam int          ACT_WORDS         = LINE_COUNT + 1;
  localparam int          PRIO_WORDS        = 8 * (LINE_COUNT + 1);

  // architecture version and options
  localparam int          ARCH_VERSION      = 2;
  localparam logic        SEC_PRESENT       = 1'b1;
  localparam logic        LOCK_PRESENT      = 1'b1;
  localparam int          LOCK_FIRST_ID     = 32;  // lockable shared lines start here

  // implemented interrupts and priority bits
  localparam logic [NINTR-1:0]   IMPL_MASK = {NINTR{1'b1}};
  localparam logic [FIELD_W-1:0] PRIO_MASK = 8'hF8;
  localparam logic [FIELD_W-1:0] PRIO_TOP  = 8'h80;
  localparam logic [FIELD_W-1:0] PRIO_RST  = 8'h00;

  // register map (byte addresses on a 12-bit bus)
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;
  localparam int          STRB_W            = 4;
  localparam logic [11:0] ACT_BASE          = 12'h380;
  localparam logic [11:0] ACT_LAST          = 12'h3FC;
  localparam logic [11:0] PRIO_BASE         = 12'h400;
  localparam logic [11:0] PRIO_LAST         = 12'h7FC;
  localparam int          PROT_NS_BIT       = 1;

endpackage : dist_pkg

/* File: rtl/active_prio_regs.sv */
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module active_prio_regs
  import dist_pkg::*;
(
  // clock and reset
  input  wire logic                             CLK,
  input  wire logic                             RST_N,
  // apb slave
  input  wire logic                             PSEL,
  input  wire logic                             PENABLE,
  input  wire logic                             PWRITE,
  input  wire logic [ADDR_W-1:0]                PADDR,
  input  wire logic [DATA_W-1:0]                PWDATA,
  input  wire logic [STRB_W-1:0]                PSTRB,
  input  wire logic [2:0]                       PPROT,
  output logic                                  PREADY,
  output logic [DATA_W-1:0]                     PRDATA,
  output logic                                  PSLVERR,
  // requesting processor, valid with the apb request
  input  wire logic [CPU_W-1:0]                 PCPU,
  // distributor side configuration
  input  wire logic [NINTR-1:0]                 GROUP1,
  input  wire logic                             CFG_LOCK,
  // activation events from the acknowledge logic
  input  wire logic [NINTR-1:0]                 ACT_SET,
  input  wire logic [CPU_W-1:0]                 ACT_CPU,
  // per-interrupt state towards the rest of the distributor
  output logic [NSPI-1:0]                       ACTIVE_SPI,
  output logic [NCPU-1:0][BANKED_INTR-1:0]      ACTIVE_BANK,
  output logic [NSPI-1:0][FIELD_W-1:0]          PRIO_SPI,
  output logic [NCPU-1:0][BANKED_INTR-1:0][FIELD_W-1:0] PRIO_BANK,
  // highest-priority active interrupt per processor
  output logic [NCPU-1:0]                       TOP_VALID,
  output logic [NCPU-1:0][ID_W-1:0]             TOP_ID,
  output logic [NCPU-1:0][FIELD_W-1:0]          TOP_PRIO
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------

  // banked copies are indexed by processor and shared lines are not, so the
  // storage is no larger than the banking rules ask for; everything that the
  // bus or the distributor sees lives in this one struct and one register
  typedef struct packed {
    logic [NSPI-1:0]                              act_spi;
    logic [NCPU-1:0][BANKED_INTR-1:0]             act_bank;
    logic [NSPI-1:0][FIELD_W-1:0]                 prio_spi;
    logic [NCPU-1:0][BANKED_INTR-1:0][FIELD_W-1:0] prio_bank;
    logic                                         pready;
    logic                                         pslverr;
    logic [DATA_W-1:0]                            prdata;
    logic [NCPU-1:0]                              top_valid;
    logic [NCPU-1:0][ID_W-1:0]                    top_id;
    logic [NCPU-1:0][FIELD_W-1:0]                 top_prio;
  } state_t;

  state_t q;
  state_t d;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // the same screen serves both register arrays, so a read and a write of an
  // entry can never disagree about whether it is hidden
  // an entry is visible when implemented and not a group 0 entry seen non-secure
  function automatic logic visible(input int m, input logic ns, input logic [NINTR-1:0] grp1);
    logic ok;
    ok = IMPL_MASK[m];
    if (SEC_PRESENT && ns && !grp1[m])
    begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // active bit of interrupt m as seen by processor c
  // callers keep c in range; ids above the banked limit ignore it
  function automatic logic act_of(input state_t s, input int m, input int c);
    logic a;
    if (m < BANKED_INTR)
    begin
      a = s.act_bank[c][m];
    end
    else
    begin
      a = s.act_spi[m - BANKED_INTR];
    end
    return a;
  endfunction

  // stored priority of interrupt m as seen by processor c
  function automatic logic [FIELD_W-1:0] prio_of(input state_t s, input int m, input int c);
    logic [FIELD_W-1:0] p;
    if (m < BANKED_INTR)
    begin
      p = s.prio_bank[c][m];
    end
    else
    begin
      p = s.prio_spi[m - BANKED_INTR];
    end
    return p;
  endfunction

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------

  // decode scratch; each one is given a value at the top of the process so no
  // path through the decode leaves a latch behind
  logic              req;
  logic              ns;
  int                cpu;
  int                idx;
  int                m;
  logic [11:0]       off;
  logic [DATA_W-1:0] rd;
  logic [FIELD_W-1:0] wv;
  logic [FIELD_W-1:0] rv;
  logic              locked;
  int                act_cpu;

  always_comb
  begin
    d       = q;
    req     = PSEL && PENABLE && !q.pready;  // one wait state, answer from a flop
    ns      = PPROT[PROT_NS_BIT];
    cpu     = int'(PCPU);
    act_cpu = int'(ACT_CPU);
    idx     = 0;
    m       = 0;
    off     = 12'h000;
    rd      = '0;
    wv      = '0;
    rv      = '0;
    locked  = 1'b0;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;

    // the answer always costs one wait state: read data come from a flop, so
    // the deep decode below never sits on the bus return path
    // register access; decode by region, unmapped space answers with an error
    if (req)
    begin
      d.pready = 1'b1;
      if (PADDR >= ACT_BASE && PADDR <= ACT_LAST)
      begin
        off = PADDR - ACT_BASE;
        idx = int'(off[11:2]);
        // version one leaves the whole window reserved: reads zero, no effect
        // the window stays decoded in both versions, so it never raises an error
        if (ARCH_VERSION == 2 && idx < ACT_WORDS)
        begin
          for (int b = 0; b < INTR_PER_WORD; b++)
          begin
            m = idx * INTR_PER_WORD + b;
            if (visible(m, ns, GROUP1))
            begin
              rd[b] = act_of(q, m, cpu);
              // a 1 deactivates; a 0 or an inactive entry leaves it alone
              if (PWRITE && PWDATA[b] && PSTRB[b / FIELD_W])
              begin
                if (m < BANKED_INTR)
                begin
                  d.act_bank[cpu][m] = 1'b0;
                end
                else
                begin
                  d.act_spi[m - BANKED_INTR] = 1'b0;
                end
              end
            end
          end
        end
      end
      else if (PADDR >= PRIO_BASE && PADDR <= PRIO_LAST)
      begin
        off = PADDR - PRIO_BASE;
        idx = int'(off[11:2]);
        if (idx < PRIO_WORDS)
        begin
          for (int l = 0; l < FIELDS_PER_WORD; l++)
          begin
            m = idx * FIELDS_PER_WORD + l;
            if (visible(m, ns, GROUP1))
            begin
              // one common copy; non-secure sees a shifted view of it
              // the shift drops the stored top bit, which non-secure writes always set
              rv = prio_of(q, m, cpu) & PRIO_MASK;
              if (ns)
              begin
                rv = {rv[FIELD_W-2:0], 1'b0};
              end
              rd[l*FIELD_W +: FIELD_W] = rv;
              wv = PWDATA[l*FIELD_W +: FIELD_W];
              if (ns)
              begin
                wv = (PRIO_TOP | {1'b0, wv[FIELD_W-1:1]}) & PRIO_MASK;
              end
              else
              begin
                wv = wv & PRIO_MASK;
              end
              // lockdown freezes group 0 shared entries even for secure writes
              // banked ids are never lockable, whatever their group
              locked = LOCK_PRESENT && CFG_LOCK && !GROUP1[m]
                       && m >= LOCK_FIRST_ID;
              // each lane is written only under its own strobe
              if (PWRITE && PSTRB[l] && !locked)
              begin
                if (m < BANKED_INTR)
                begin
                  d.prio_bank[cpu][m] = wv;
                end
                else
                begin
                  d.prio_spi[m - BANKED_INTR] = wv;
                end
              end
            end
          end
        end
      end
      else
      begin
        d.pslverr = 1'b1;
      end
      d.prdata = PWRITE ? '0 : rd;
    end

    // activation comes after the clear so a simultaneous set wins
    // a clear-active write that meets an activation of the same id in one cycle
    // therefore reads back as active; software has to write the bit again
    for (int k = 0; k < NINTR; k++)
    begin
      if (ACT_SET[k])
      begin
        if (k < BANKED_INTR)
        begin
          d.act_bank[act_cpu][k] = 1'b1;
        end
        else
        begin
          d.act_spi[k - BANKED_INTR] = 1'b1;
        end
      end
    end

    // running priority per processor over active entries; ties keep the lower id
    // this search is one long chain over every id; acceptable for the small
    // line count here, a wider build would want it split over cycles
    for (int c = 0; c < NCPU; c++)
    begin
      d.top_valid[c] = 1'b0;
      d.top_id[c]    = '0;
      d.top_prio[c]  = '0;
      for (int k = 0; k < NINTR; k++)
      begin
        if (act_of(q, k, c) && IMPL_MASK[k]
            && (!d.top_valid[c] || prio_of(q, k, c) < d.top_prio[c]))
        begin
          d.top_valid[c] = 1'b1;
          d.top_id[c]    = ID_W'(k);
          d.top_prio[c]  = prio_of(q, k, c);
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------

  // synchronous reset: nothing active, all priorities at their reset value
  // the whole struct is cleared, so the running-priority result and the bus
  // answer come up idle together with the state they are derived from
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      q.act_spi   <= '0;
      q.act_bank  <= '0;
      q.prio_spi  <= {NSPI{PRIO_RST}};
      q.prio_bank <= {(NCPU*BANKED_INTR){PRIO_RST}};
      q.pready    <= 1'b0;
      q.pslverr   <= 1'b0;
      q.prdata    <= '0;
      q.top_valid <= '0;
      q.top_id    <= '0;
      q.top_prio  <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all taken from the state register
  // ------------------------------------------------------------------

  // straight wires from the register: the distributor never sees decode glitches
  assign PREADY      = q.pready;
  assign PSLVERR     = q.pslverr;
  assign PRDATA      = q.prdata;
  assign ACTIVE_SPI  = q.act_spi;
  assign ACTIVE_BANK = q.act_bank;
  assign PRIO_SPI    = q.prio_spi;
  assign PRIO_BANK   = q.prio_bank;
  assign TOP_VALID   = q.top_valid;
  assign TOP_ID      = q.top_id;
  assign TOP_PRIO    = q.top_prio;

endmodule // active_prio_regs

`default_nettype wire

/* File: sim/dist_chk_sva.sv */
`timescale 1ns/10ps
`default_nettype none

module dist_chk
  import dist_pkg::*;
(
  // clock and reset
  input wire logic                       CLK,
  input wire logic                       RST_N,
  // apb
  input wire logic                       PSEL,
  input wire logic                       PENABLE,
  input wire logic                       PWRITE,
  input wire logic [ADDR_W-1:0]          PADDR,
  input wire logic [DATA_W-1:0]          PWDATA,
  input wire logic [STRB_W-1:0]          PSTRB,
  input wire logic [2:0]                 PPROT,
  input wire logic                       PREADY,
  input wire logic [DATA_W-1:0]          PRDATA,
  input wire logic                       PSLVERR,
  // state
  input wire logic [NINTR-1:0]           GROUP1,
  input wire logic                       CFG_LOCK,
  input wire logic [NINTR-1:0]           ACT_SET,
  input wire logic [NSPI-1:0]            ACTIVE_SPI,
  input wire logic [NCPU-1:0][31:0]      ACTIVE_BANK,
  input wire logic [NSPI-1:0][7:0]       PRIO_SPI,
  input wire logic [NCPU-1:0]            TOP_VALID
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // helpers kept out of properties so $past sees plain nets
  logic low_bits;
  logic clr_cyc;
  assign clr_cyc = PSEL && PENABLE && !PREADY && PWRITE && PADDR == 12'h384;
  always_comb
  begin
    low_bits = 1'b0;
    for (int i = 0; i < NSPI; i++)
      low_bits = low_bits | (|(PRIO_SPI[i] & ~PRIO_MASK));
  end

  sequence s_acc;
    PSEL && PENABLE && !PREADY;
  endsequence

  property p_ready;
    s_acc |=> PREADY ##1 !PREADY;
  endproperty
  property p_err;
    s_acc ##0 (PADDR < 12'h380) |=> PSLVERR;
  endproperty
  property p_noerr;
    s_acc ##0 (PADDR >= 12'h380 && PADDR <= 12'h7FC) |=> !PSLVERR;
  endproperty
  property p_wdata;
    s_acc ##0 PWRITE |=> PRDATA == '0;
  endproperty
  property p_act;
    ACT_SET[63:32] != '0 |=> (ACTIVE_SPI & $past(ACT_SET[63:32])) == $past(ACT_SET[63:32]);
  endproperty
  property p_clear;
    s_acc ##0 (clr_cyc && PSTRB == 4'hF && !PPROT[1])
      |=> (ACTIVE_SPI & $past(PWDATA) & ~$past(ACT_SET[63:32])) == '0;
  endproperty
  property p_keep;
    $past(RST_N) && !$past(clr_cyc) |-> ($past(ACTIVE_SPI) & ~ACTIVE_SPI) == '0;
  endproperty
  property p_mask;
    !low_bits;
  endproperty
  property p_lock;
    s_acc ##0 (PWRITE && CFG_LOCK && !GROUP1[35] && PADDR == 12'h420)
      |=> $stable(PRIO_SPI[3]);
  endproperty
  property p_nsg0;
    s_acc ##0 (!PWRITE && PPROT[1] && !GROUP1[35] && PADDR == 12'h420)
      |=> PRDATA[31:24] == 8'h00;
  endproperty
  property p_top;
    (ACTIVE_SPI == '0 && ACTIVE_BANK[0] == '0) |=> !TOP_VALID[0];
  endproperty

  a_ready: assert property (p_ready) else $error("no single ready pulse");
  a_err: assert property (p_err) else $error("unmapped access not refused");
  a_noerr: assert property (p_noerr) else $error("mapped access refused");
  a_wdata: assert property (p_wdata) else $error("read data not zero on write");
  a_act: assert property (p_act) else $error("activation lost");
  a_clear: assert property (p_clear) else $error("clear-active left bit set");
  a_keep: assert property (p_keep) else $error("active bit fell without clear");
  a_mask: assert property (p_mask) else $error("low priority bits set");
  a_lock: assert property (p_lock) else $error("locked priority changed");
  a_nsg0: assert property (p_nsg0) else $error("group 0 priority visible");
  a_top: assert property (p_top) else $error("top valid with none active");
endmodule // dist_chk

bind active_prio_regs dist_chk dist_chk_i (
  .CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PPROT, .PREADY,
  .PRDATA, .PSLVERR, .GROUP1, .CFG_LOCK, .ACT_SET, .ACTIVE_SPI, .ACTIVE_BANK,
  .PRIO_SPI, .TOP_VALID
);

`default_nettype wire

/* File: sim/active_prio_regs_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end

module active_prio_regs_tb_top;
  import dist_pkg::*;
  // ---------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------
  logic              CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic              PWRITE = 1'b0, CFG_LOCK = 1'b0, PREADY, PSLVERR, err, ns = 1'b0;
  logic [11:0]       PADDR = '0;
  logic [31:0]       PWDATA = '0, PRDATA, rdat;
  logic [3:0]        PSTRB = '0;
  logic [2:0]        PPROT = '0;
  logic [CPU_W-1:0]  PCPU = '0, ACT_CPU = '0, cpu = '0;
  logic [NINTR-1:0]  GROUP1 = 64'hFFFFFFF7_FFFFFFFF; // id 35 is group 0
  logic [NINTR-1:0]  ACT_SET = '0;
  logic [NSPI-1:0]                               ACTIVE_SPI;
  logic [NCPU-1:0][BANKED_INTR-1:0]              ACTIVE_BANK;
  logic [NSPI-1:0][FIELD_W-1:0]                  PRIO_SPI;
  logic [NCPU-1:0][BANKED_INTR-1:0][FIELD_W-1:0] PRIO_BANK;
  logic [NCPU-1:0]                               TOP_VALID;
  logic [NCPU-1:0][ID_W-1:0]                     TOP_ID;
  logic [NCPU-1:0][FIELD_W-1:0]                  TOP_PRIO;
  int                error_cnt = 0, check_count = 0;

  always #5 CLK = ~CLK;

  active_prio_regs active_prio_regs_i (
    .CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PPROT, .PREADY,
    .PRDATA, .PSLVERR, .PCPU, .GROUP1, .CFG_LOCK, .ACT_SET, .ACT_CPU, .ACTIVE_SPI,
    .ACTIVE_BANK, .PRIO_SPI, .PRIO_BANK, .TOP_VALID, .TOP_ID, .TOP_PRIO
  );

  // ---------------------------------------------
  // bus tasks
  // ---------------------------------------------
  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer; starts a clock later so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    PPROT <= {1'b0, ns, 1'b0};
    PCPU <= cpu;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1)
    begin
      $display("[ERR] t=%0t got %h exp %h", $time, PREADY, 1'b1);
      error_cnt++;
      stop_test();
    end
    rdat = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    `CHK(rdat, e)
    `CHK(err, 1'b0)
  endtask

  // one-cycle activation pulse from the acknowledge side
  task automatic act(input int id, input logic [CPU_W-1:0] c);
    ACT_SET <= 64'h1 << id;
    ACT_CPU <= c;
    @(posedge CLK);
    ACT_SET <= '0;
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    rd(12'h420, 32'h0000_0000);
    wr(12'h420, 32'hFFFF_FFFF, 4'h2);
    rd(12'h420, 32'h0000_F800);
    wr(12'h420, 32'h0000_0012, 4'h1);
    rd(12'h420, 32'h0000_F810);
    ns = 1'b1;
    wr(12'h420, 32'h0040_0000, 4'h4);
    rd(12'h420, 32'h0040_F020);
    wr(12'h420, 32'h5000_0000, 4'h8);
    ns = 1'b0;
    rd(12'h420, 32'h00A0_F810);
    wr(12'h420, 32'h3000_0000, 4'h8);
    CFG_LOCK <= 1'b1;
    wr(12'h420, 32'h6000_0000, 4'h8);
    rd(12'h420, 32'h30A0_F810);
    `CHK(PRIO_SPI[3], 8'h30)
    CFG_LOCK <= 1'b0;
    wr(12'h400, 32'h0000_0040, 4'h1);
    cpu = 1'b1;
    rd(12'h400, 32'h0000_0000);
    cpu = 1'b0;
    rd(12'h400, 32'h0000_0040);
    `CHK(PRIO_BANK[0][0], 8'h40)
    `CHK(PRIO_BANK[1][0], 8'h00)
    rd(12'h440, 32'h0000_0000);
    rd(12'h7FC, 32'h0000_0000);
    rd(12'h388, 32'h0000_0000);
    rd(12'h3FC, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000, 4'h0);
    `CHK(err, 1'b1)
    // active bits: set from the acknowledge side, cleared by software
    act(40, 1'b0);
    rd(12'h384, 32'h0000_0100);
    `CHK(ACTIVE_SPI, 32'h0000_0100)
    wr(12'h384, 32'hFFFF_FEFF, 4'hF);
    rd(12'h384, 32'h0000_0100);
    act(35, 1'b0);
    ns = 1'b1;
    rd(12'h384, 32'h0000_0100);
    wr(12'h384, 32'h0000_0008, 4'h1);
    ns = 1'b0;
    rd(12'h384, 32'h0000_0108);
    // ids 35 (0x30) and 40 (0x00) active: the lower value wins
    `CHK(TOP_VALID[0], 1'b1)
    `CHK(TOP_ID[0], 6'h28)
    `CHK(TOP_PRIO[0], 8'h00)
    wr(12'h428, 32'h0000_0080, 4'h1);
    rd(12'h428, 32'h0000_0080);
    `CHK(TOP_ID[0], 6'h23)
    `CHK(TOP_PRIO[0], 8'h30)
    wr(12'h384, 32'h0000_0108, 4'h3);
    rd(12'h384, 32'h0000_0000);
    act(5, 1'b1);
    rd(12'h380, 32'h0000_0000);
    cpu = 1'b1;
    rd(12'h380, 32'h0000_0020);
    `CHK(ACTIVE_BANK[1], 32'h0000_0020)
    `CHK(TOP_VALID, 2'h2)
    `CHK(TOP_ID[1], 6'h05)
    wr(12'h380, 32'h0000_0020, 4'h1);
    rd(12'h380, 32'h0000_0000);
    `CHK(TOP_VALID, 2'h0)
    stop_test();
  end
endmodule // active_prio_regs_tb_top

`default_nettype wire
